/* rtl/ct_defines.svh */
// Purpose: Constants for the CAN transceiver control logic
// Assumes: 100 MHz system clock
// Notes:   Included by bare name; definitions only
`ifndef CT_DEFINES_SVH
`define CT_DEFINES_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CT_CLK_NS 10
`define CT_TICK_NS 1000
`define CT_TICK_CYC (`CT_TICK_NS / `CT_CLK_NS)
`define CT_TIMEOUT_NS 1250000
`define CT_TIMEOUT_TICKS ((`CT_TIMEOUT_NS + `CT_TICK_NS - 1) / `CT_TICK_NS)
`define CT_STBY_DIV 8
`define CT_CNT_W 16

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define CT_ADDR_CTRL 8'h00
`define CT_ADDR_STATUS 8'h04
`define CT_ADDR_EVENT 8'h08

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CT_CTRL_DRV_EN 0
`define CT_CTRL_FORCE_STBY 1
`define CT_CTRL_RESET 32'h0000_0001
`define CT_CTRL_MASK 32'h0000_0003
`define CT_SYNC_RESET 8'h01
`define CT_ST_DRIVING 0
`define CT_ST_TIMEOUT 1
`define CT_ST_OVERTEMP 2
`define CT_ST_RXD 3
`define CT_ST_MODE_LO 4
`define CT_ST_PWR_LO 6
`define CT_EV_TRIP 0
`define CT_EV_OVERTEMP 1

`endif

/* rtl/ct_pkg.sv */
// Purpose: Types for the CAN transceiver control logic
// Assumes: Nothing beyond the defines header
// Notes:   One-hot codes are written out
package ct_pkg;

  // ----------------------------------------
  // Operating mode from the level detector
  // ----------------------------------------
  typedef enum logic [1:0] {
    CT_MODE_HIGH_SPEED = 2'h0,
    CT_MODE_SLOPE = 2'h1,
    CT_MODE_STANDBY = 2'h2
  } ct_mode_t;

  // ----------------------------------------
  // Power-up sequencing of the drivers
  // ----------------------------------------
  typedef enum logic [2:0] {
    CT_PWR_OFF = 3'h1,
    CT_PWR_ARMING = 3'h2,
    CT_PWR_ON = 3'h4
  } ct_pwr_t;

endpackage : ct_pkg

/* rtl/ct_timer_if.sv */
// Purpose: Carrier between the control logic and the stuck timer
// Assumes: Single clock domain
// Notes:   txd_low is already synchronised
`timescale 1ns/100ps
interface ct_timer_if;
  logic txd_low;
  logic expired;
  modport ctrl (output txd_low, input expired);
  modport timer (input txd_low, output expired);
endinterface : ct_timer_if

/* rtl/ct_stuck_timer.sv */
// Purpose: Times continuous low on the transmit input
// Assumes: txd_low is synchronous to clk
// Notes:   Prescaler restarts with each low run, so trips are exact
`timescale 1ns/100ps
`include "ct_defines.svh"
module ct_stuck_timer import ct_pkg::*; #(
  parameter int unsigned TICK_CYC = `CT_TICK_CYC,
  parameter int unsigned TIMEOUT_TICKS = `CT_TIMEOUT_TICKS
) (
  input wire logic clk,
  input wire logic sys_rst,
  ct_timer_if.timer tif
);

  logic [`CT_CNT_W-1:0] presc;
  logic [`CT_CNT_W-1:0] ticks;
  logic wrap;

  assign wrap = (presc == `CT_CNT_W'(TICK_CYC - 1));

  // ----------------------------------------
  // Time base and tick counter
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      presc <= '0;
      ticks <= '0;
    end else if (!tif.txd_low || tif.expired) begin
      presc <= '0;
      ticks <= '0;
    end else if (wrap) begin
      presc <= '0;
      ticks <= ticks + `CT_CNT_W'(1);
    end else begin
      presc <= presc + `CT_CNT_W'(1);
    end
  end

  // ----------------------------------------
  // Expiry: held while low, cleared by high
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tif.expired <= 1'b0;
    end else if (!tif.txd_low) begin
      tif.expired <= 1'b0;
    end else if (wrap && ticks == `CT_CNT_W'(TIMEOUT_TICKS - 1)) begin
      tif.expired <= 1'b1;
    end
  end

endmodule : ct_stuck_timer

/* rtl/ct_xcvr_ctrl.sv */
// Purpose: Digital control of a high speed CAN transceiver
// Assumes: Pins and analog detectors arrive asynchronously
// Notes:   AHB-Lite slave, zero wait states, always OKAY
//
// Behaviour
// - Enabled, not standby: low transmit drives dominant, high leaves undriven.
// - Receive output low on dominant bus, high on recessive bus.
// - Dominant from another node reads zero regardless of local drive.
// - Foreign dominant overrides locally requested recessive level.
// - Transmit low beyond minimum timeout disables both drivers.
// - Drivers stay off while low; rising edge clears timer, re-enables.
// - Lines stay undriven until upper power-on threshold is reached.
// - Transmit low at supply-good keeps drivers off until seen high.
// - Supply below lower threshold returns lines to undriven.
// - Standby turns transmitter off; receive works at reduced speed.
// - Grounded mode input selects fast high speed drive.
// - Intermediate mode level selects slope-limited drive.
// - Over-temperature disables only the drivers; receive keeps going.
// - Floating transmit input counts as high, giving recessive.
// - Below nominal supply, same truth table holds above threshold.
// - Paths support the maximum bus signalling rate.
//
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "ct_defines.svh"
module ct_xcvr_ctrl import ct_pkg::*; #(
  parameter int unsigned TICK_CYC = `CT_TICK_CYC,
  parameter int unsigned TIMEOUT_TICKS = `CT_TIMEOUT_TICKS
) (
  input wire logic clk,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Controller side
  input wire logic txd_pin,
  input wire logic txd_driven,
  output logic rxd,
  // Bus side
  input wire logic bus_dominant,
  output logic canh_out,
  output logic canh_oe,
  output logic canl_out,
  output logic canl_oe,
  // Analog detectors
  input wire logic [1:0] mode_select_pin,
  input wire logic power_on_upper_threshold,
  input wire logic power_on_lower_threshold,
  input wire logic over_temp,
  output logic slope_ctrl_en
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic ct_mode_t ct_decode_mode(input logic [1:0] code);
    if (code[1]) begin
      return CT_MODE_STANDBY;
    end else if (code[0]) begin
      return CT_MODE_SLOPE;
    end else begin
      return CT_MODE_HIGH_SPEED;
    end
  endfunction : ct_decode_mode

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0] meta;
  logic [7:0] sync;
  logic txd_pin_s;
  logic txd_driven_s;
  logic bus_dom_s;
  logic [1:0] mode_s;
  logic upper_ok_s;
  logic lower_ok_s;
  logic over_temp_s;
  logic txd_level;
  ct_mode_t mode;
  ct_pwr_t pwr_state;
  ct_pwr_t next_pwr_state;
  logic drv_allow;
  logic drive_dom;
  logic [$clog2(`CT_STBY_DIV)-1:0] stby_cnt;
  logic stby_sample;
  logic [31:0] ctrl;
  logic ev_trip;
  logic ev_overtemp;
  logic expired_d;
  logic over_temp_d;
  logic trip_rise;
  logic ot_rise;
  logic dp_write;
  logic [7:0] dp_addr;
  logic ap_valid;
  logic [31:0] status_word;
  logic [31:0] event_word;
  logic [31:0] read_word;

  ct_timer_if tif ();

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Reset values: transmit high, bus recessive, supply absent
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= `CT_SYNC_RESET;
      sync <= `CT_SYNC_RESET;
    end else begin
      meta <= {over_temp, power_on_lower_threshold,
               power_on_upper_threshold, mode_select_pin,
               bus_dominant, txd_driven, txd_pin};
      sync <= meta;
    end
  end

  assign txd_pin_s = sync[0];
  assign txd_driven_s = sync[1];
  assign bus_dom_s = sync[2];
  assign mode_s = sync[4:3];
  assign upper_ok_s = sync[5];
  assign lower_ok_s = sync[6];
  assign over_temp_s = sync[7];

  // Pull-up: an undriven input reads as recessive
  assign txd_level = txd_driven_s ? txd_pin_s : 1'b1;

  assign mode = ct_decode_mode(mode_s);

  // ----------------------------------------
  // Stuck-dominant timer
  // ----------------------------------------
  assign tif.txd_low = !txd_level;

  ct_stuck_timer #(
    .TICK_CYC(TICK_CYC),
    .TIMEOUT_TICKS(TIMEOUT_TICKS)
  ) u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .tif(tif)
  );

  // ----------------------------------------
  // Power-on sequencing
  // ----------------------------------------
  always_comb begin
    next_pwr_state = pwr_state;
    unique case (pwr_state)
      CT_PWR_OFF: begin
        if (upper_ok_s && lower_ok_s) begin
          next_pwr_state = CT_PWR_ARMING;
        end
      end
      CT_PWR_ARMING: begin
        if (!lower_ok_s) begin
          next_pwr_state = CT_PWR_OFF;
        end else if (txd_level) begin
          next_pwr_state = CT_PWR_ON;
        end
      end
      CT_PWR_ON: begin
        if (!lower_ok_s) begin
          next_pwr_state = CT_PWR_OFF;
        end
      end
      default: begin
        next_pwr_state = CT_PWR_OFF;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_state <= CT_PWR_OFF;
    end else begin
      pwr_state <= next_pwr_state;
    end
  end

  // ----------------------------------------
  // Driver control
  // ----------------------------------------
  // Upper threshold only matters while off: this gives the hysteresis.
  // Supply range inside the window does not alter the table.
  assign drv_allow = (pwr_state == CT_PWR_ON)
                     && !tif.expired
                     && !over_temp_s
                     && (mode != CT_MODE_STANDBY)
                     && !ctrl[`CT_CTRL_FORCE_STBY]
                     && ctrl[`CT_CTRL_DRV_EN];

  assign drive_dom = drv_allow && !txd_level;

  // One flop from pin sync to driver keeps latency well under a bit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      canh_oe <= 1'b0;
      canl_oe <= 1'b0;
    end else begin
      canh_oe <= drive_dom;
      canl_oe <= drive_dom;
    end
  end

  // Dominant levels; recessive is simply not driving
  assign canh_out = 1'b1;
  assign canl_out = 1'b0;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slope_ctrl_en <= 1'b0;
    end else begin
      // High speed leaves this low for fast edges
      slope_ctrl_en <= (mode == CT_MODE_SLOPE);
    end
  end

  // ----------------------------------------
  // Receive path
  // ----------------------------------------
  // Standby samples the bus only every few cycles, trading speed for
  // power; a short dominant bit may be missed there.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stby_cnt <= '0;
    end else begin
      stby_cnt <= stby_cnt + 1'b1;
    end
  end

  assign stby_sample = (stby_cnt == '0);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxd <= 1'b1;
    end else if (mode != CT_MODE_STANDBY || stby_sample) begin
      // Sensed bus, not local transmit: wired-dominant readback
      rxd <= !bus_dom_s;
    end
  end

  // ----------------------------------------
  // Event flags
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      expired_d <= 1'b0;
      over_temp_d <= 1'b0;
    end else begin
      expired_d <= tif.expired;
      over_temp_d <= over_temp_s;
    end
  end

  assign trip_rise = tif.expired && !expired_d;
  assign ot_rise = over_temp_s && !over_temp_d;

  // Set wins over a same-cycle write-one-to-clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ev_trip <= 1'b0;
      ev_overtemp <= 1'b0;
    end else begin
      if (trip_rise) begin
        ev_trip <= 1'b1;
      end else if (dp_write && dp_addr == `CT_ADDR_EVENT
                   && hwdata[`CT_EV_TRIP]) begin
        ev_trip <= 1'b0;
      end
      if (ot_rise) begin
        ev_overtemp <= 1'b1;
      end else if (dp_write && dp_addr == `CT_ADDR_EVENT
                   && hwdata[`CT_EV_OVERTEMP]) begin
        ev_overtemp <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ap_valid = hsel && hready && htrans[1];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_write <= ap_valid && hwrite;
      dp_addr <= ap_valid ? haddr[7:0] : 8'h00;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= `CT_CTRL_RESET;
    end else if (dp_write && dp_addr == `CT_ADDR_CTRL) begin
      // Only the two control bits are kept
      ctrl <= hwdata & `CT_CTRL_MASK;
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`CT_ST_DRIVING] = drv_allow;
    status_word[`CT_ST_TIMEOUT] = tif.expired;
    status_word[`CT_ST_OVERTEMP] = over_temp_s;
    status_word[`CT_ST_RXD] = rxd;
    status_word[`CT_ST_MODE_LO +: 2] = mode;
    status_word[`CT_ST_PWR_LO +: 3] = pwr_state;
  end

  always_comb begin
    event_word = 32'h0000_0000;
    event_word[`CT_EV_TRIP] = ev_trip;
    event_word[`CT_EV_OVERTEMP] = ev_overtemp;
  end

  // Unmapped and misaligned addresses read zero
  always_comb begin
    unique case (haddr[7:0])
      `CT_ADDR_CTRL: read_word = ctrl;
      `CT_ADDR_STATUS: read_word = status_word;
      `CT_ADDR_EVENT: read_word = event_word;
      default: read_word = 32'h0000_0000;
    endcase
    if (haddr[31:8] != 24'h00_0000) begin
      read_word = 32'h0000_0000;
    end
  end

  // Captured at the address phase so it stands in the data phase
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_valid && !hwrite) begin
      hrdata <= read_word;
    end
  end

endmodule : ct_xcvr_ctrl

/* tb/ct_xcvr_chk.sv */
// Purpose: Port checks for the transceiver control logic
// Assumes: One clock; reset active high
// Notes: Bound from the bench top file
`timescale 1ns/100ps
module ct_xcvr_chk #(
  parameter int unsigned TICK_CYC = 4,
  parameter int unsigned TIMEOUT_TICKS = 5
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic txd_pin,
  input wire logic txd_driven,
  input wire logic rxd,
  input wire logic bus_dominant,
  input wire logic canh_out,
  input wire logic canh_oe,
  input wire logic canl_out,
  input wire logic canl_oe,
  input wire logic [1:0] mode_select_pin,
  input wire logic power_on_lower_threshold,
  input wire logic over_temp,
  input wire logic slope_ctrl_en
);
  // ----------------------------------------
  // Drive run length
  // ----------------------------------------
  // Two cycles of slack cover the timer restart latency
  localparam int LIM = TICK_CYC * TIMEOUT_TICKS + 2;
  logic [15:0] on_cnt;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      on_cnt <= 16'h0000;
    end else begin
      on_cnt <= canh_oe ? on_cnt + 16'h0001 : 16'h0000;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  oe_pair_a: assert property (
    canl_oe == canh_oe && canh_out && !canl_out) else $error("oe pair");
  oe_cause_a: assert property (
    $rose(canh_oe) |-> $past(!txd_pin && txd_driven, 3))
    else $error("oe without low txd");
  rx_follow_a: assert property (
    !mode_select_pin[1] [*4] |-> rxd == !$past(bus_dominant, 3))
    else $error("rxd not bus");
  stuck_lim_a: assert property (on_cnt <= LIM)
    else $error("stuck drive too long");
  brown_off_a: assert property (
    !power_on_lower_threshold [*5] |-> !canh_oe) else $error("brown oe");
  stdby_off_a: assert property (
    mode_select_pin[1] [*5] |-> !canh_oe) else $error("standby oe");
  hs_mode_a: assert property (
    (mode_select_pin == 2'h0) [*4] |-> !slope_ctrl_en) else $error("hs");
  slope_mode_a: assert property (
    (mode_select_pin == 2'h1) [*4] |-> slope_ctrl_en) else $error("slope");
  hot_off_a: assert property (over_temp [*5] |-> !canh_oe)
    else $error("hot oe");
  float_off_a: assert property (
    (txd_pin || !txd_driven) [*5] |-> !canh_oe) else $error("float oe");
  cover property ($fell(canh_oe) && !txd_pin);
  cover property ($rose(canh_oe));
  cover property (mode_select_pin[1] && !rxd);
endmodule : ct_xcvr_chk

/* tb/ct_ctl_model.sv */
// Purpose: Protocol controller and bus wire model
// Assumes: Bench sets the wanted transmit level
// Notes: Floating transmit toggles the raw pin
`timescale 1ns/100ps
module ct_ctl_model (
  input wire logic clk,
  input wire logic tx_level,
  input wire logic tx_float,
  input wire logic foreign_dom,
  input wire logic canh_oe,
  input wire logic canl_oe,
  output logic txd_pin = 1'b1,
  output logic txd_driven = 1'b1,
  output logic bus_dominant
);
  // Raw pin is meaningless when released; pull-up is the device's job
  always @(posedge clk) begin
    txd_driven <= !tx_float;
    txd_pin <= tx_float ? !txd_pin : tx_level;
  end
  // Wired-dominant bus
  assign bus_dominant = (canh_oe && canl_oe) || foreign_dom;
endmodule : ct_ctl_model

/* tb/ct_xcvr_ctrl_tb.sv */
// Purpose: Self-checking bench for the transceiver control logic
// Assumes: Short timer parameters, trip after 20 low cycles
// Notes: Low runs kept under the trip count except on purpose and in the last run, from the control checks to the end
`timescale 1ns/100ps
`include "ct_defines.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
  fail_count++; $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module ct_xcvr_ctrl_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout, hresp, rxd, bus_dominant, slope_ctrl_en;
  logic [31:0] hrdata, rd;
  logic txd_pin, txd_driven, canh_out, canh_oe, canl_out, canl_oe;
  logic tx_level = 1'b1;
  logic tx_float = 1'b0;
  logic foreign_dom = 1'b0;
  logic [1:0] mode = 2'h0;
  logic por_hi = 1'b0;
  logic por_lo = 1'b0;
  logic hot = 1'b0;
  int fail_count = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  ct_xcvr_ctrl #(.TICK_CYC(4), .TIMEOUT_TICKS(5)) dut (.clk(clk),
    .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .txd_pin(txd_pin), .txd_driven(txd_driven), .rxd(rxd),
    .bus_dominant(bus_dominant), .canh_out(canh_out), .canh_oe(canh_oe),
    .canl_out(canl_out), .canl_oe(canl_oe), .mode_select_pin(mode),
    .power_on_upper_threshold(por_hi), .power_on_lower_threshold(por_lo),
    .over_temp(hot), .slope_ctrl_en(slope_ctrl_en));
  ct_ctl_model u_ctl (.clk(clk), .tx_level(tx_level), .tx_float(tx_float),
    .foreign_dom(foreign_dom), .canh_oe(canh_oe), .canl_oe(canl_oe),
    .txd_pin(txd_pin), .txd_driven(txd_driven),
    .bus_dominant(bus_dominant));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 32);
    if (hreadyout !== 1'b1) begin
      fail_count++;
      tally_and_finish;
    end
  endtask : wait_rdy
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy;
    rd = hrdata;
  endtask : ahb
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task look;
    @(negedge clk);
  endtask : look
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    cyc(8);
    sys_rst <= 1'b0;
    look;
    `CHK("oe_rst", 1'b0, canh_oe)
    `CHK("rxd_rst", 1'b1, rxd)
    ahb(1'b0, `CT_ADDR_CTRL, 32'h0);
    `CHK("ctrl_rst", `CT_CTRL_RESET, rd)
    ahb(1'b0, `CT_ADDR_STATUS, 32'h0);
    `CHK("pwr_off", 3'h1, rd[8:6])
    cyc(1);
    tx_level <= 1'b0;
    por_lo <= 1'b1;
    cyc(6);
    look;
    `CHK("oe_no_upper", 1'b0, canh_oe)
    cyc(1);
    por_hi <= 1'b1;
    cyc(6);
    look;
    `CHK("oe_armed_low", 1'b0, canh_oe)
    cyc(1);
    tx_level <= 1'b1;
    cyc(6);
    look;
    `CHK("oe_recessive", 1'b0, canh_oe)
    cyc(1);
    tx_level <= 1'b0;
    cyc(6);
    look;
    `CHK("oe_dominant", 1'b1, canh_oe)
    // Own dominant needs one more edge to come back through the receiver
    cyc(1);
    look;
    `CHK("rxd_own", 1'b0, rxd)
    // Hold low past the trip count on purpose
    cyc(14);
    look;
    `CHK("oe_before_trip", 1'b1, canh_oe)
    cyc(6);
    look;
    `CHK("oe_tripped", 1'b0, canl_oe)
    ahb(1'b0, `CT_ADDR_STATUS, 32'h0);
    `CHK("st_trip", 1'b1, rd[`CT_ST_TIMEOUT])
    `CHK("oe_still_off", 1'b0, canh_oe)
    cyc(1);
    tx_level <= 1'b1;
    cyc(4);
    tx_level <= 1'b0;
    cyc(6);
    look;
    `CHK("oe_rearm", 1'b1, canh_oe)
    cyc(1);
    tx_level <= 1'b1;
    foreign_dom <= 1'b1;
    cyc(6);
    look;
    `CHK("rxd_foreign", 1'b0, rxd)
    `CHK("oe_foreign", 1'b0, canh_oe)
    for (int m = 0; m < 3; m++) begin
      cyc(1);
      foreign_dom <= 1'b0;
      mode <= m[1:0];
      cyc(12);
      tx_level <= 1'b0;
      cyc(6);
      look;
      `CHK("oe_mode", m != 2, canh_oe)
      `CHK("slope_mode", m == 1, slope_ctrl_en)
      ahb(1'b0, `CT_ADDR_STATUS, 32'h0);
      `CHK("st_mode", m[1:0], rd[5:4])
      // Low run ends well before the trip count
      tx_level <= 1'b1;
      foreign_dom <= 1'b1;
      cyc(14);
      look;
      `CHK("rxd_mode", 1'b0, rxd)
    end
    cyc(1);
    foreign_dom <= 1'b0;
    mode <= 2'h0;
    hot <= 1'b1;
    tx_level <= 1'b0;
    cyc(6);
    foreign_dom <= 1'b1;
    cyc(5);
    look;
    `CHK("oe_hot", 1'b0, canh_oe)
    `CHK("rxd_hot", 1'b0, rxd)
    cyc(1);
    hot <= 1'b0;
    foreign_dom <= 1'b0;
    tx_level <= 1'b1;
    tx_float <= 1'b1;
    cyc(6);
    look;
    `CHK("oe_float", 1'b0, canh_oe)
    cyc(1);
    tx_float <= 1'b0;
    tx_level <= 1'b0;
    ahb(1'b1, `CT_ADDR_CTRL, 32'h0);
    cyc(4);
    look;
    `CHK("oe_ctrl_off", 1'b0, canh_oe)
    ahb(1'b1, `CT_ADDR_CTRL, `CT_CTRL_RESET);
    cyc(5);
    look;
    `CHK("oe_ctrl_on", 1'b1, canh_oe)
    ahb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0000_0000, rd)
    por_lo <= 1'b0;
    cyc(5);
    look;
    `CHK("oe_brown", 1'b0, canh_oe)
    ahb(1'b0, `CT_ADDR_STATUS, 32'h0);
    `CHK("pwr_brown", 3'h1, rd[8:6])
    ahb(1'b0, `CT_ADDR_EVENT, 32'h0);
    `CHK("ev_seen", 32'h0000_0003, rd)
    ahb(1'b1, `CT_ADDR_EVENT, 32'h0000_0003);
    ahb(1'b0, `CT_ADDR_EVENT, 32'h0);
    `CHK("ev_clear", 32'h0000_0000, rd)
    tally_and_finish;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    tally_and_finish;
  end
endmodule : ct_xcvr_ctrl_tb
bind ct_xcvr_ctrl ct_xcvr_chk #(.TICK_CYC(TICK_CYC),
  .TIMEOUT_TICKS(TIMEOUT_TICKS)) u_chk (.clk(clk), .sys_rst(sys_rst),
  .txd_pin(txd_pin), .txd_driven(txd_driven), .rxd(rxd),
  .bus_dominant(bus_dominant), .canh_out(canh_out), .canh_oe(canh_oe),
  .canl_out(canl_out), .canl_oe(canl_oe),
  .mode_select_pin(mode_select_pin),
  .power_on_lower_threshold(power_on_lower_threshold),
  .over_temp(over_temp), .slope_ctrl_en(slope_ctrl_en));
